// ==== src/ssp_cfg.svh ====
// Register offsets, field positions, reset values and mode codes of the serial port.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef SSP_CFG_SVH
`define SSP_CFG_SVH

// ==========================================
// Register byte offsets
`define SSP_OFF_CTRL 8'h14
`define SSP_OFF_STAT 8'h94
`define SSP_OFF_BUF 8'h18
`define SSP_OFF_ADDR 8'h1C

// ==========================================
// Control fields and reset values
`define SSP_BIT_WRITE_COLLISION_FLAG 7
`define SSP_BIT_OV 6
`define SSP_BIT_EN 5
`define SSP_BIT_CKP 4
`define SSP_CTRL_RST 8'h00
`define SSP_BYTE_RST 8'h00

// ==========================================
// Mode select codes
`define SSP_M_DIV4 4'h0
`define SSP_M_DIV16 4'h1
`define SSP_M_DIV64 4'h2
`define SSP_M_TMR 4'h3
`define SSP_M_SLV_SS 4'h4
`define SSP_M_SLV_NOSS 4'h5
`define SSP_M_I2C7 4'h6
`define SSP_M_I2C10 4'h7
`define SSP_M_I2CFW 4'hB
`define SSP_M_I2C7SP 4'hE
`define SSP_M_I2C10SP 4'hF

// ==========================================
// Serial clock half periods in system clocks, and the edge count of the last shift edge
`define SSP_HALF_DIV4 6'h02
`define SSP_HALF_DIV16 6'h08
`define SSP_HALF_DIV64 6'h20
`define SSP_LAST_EDGE 4'hF

`endif

// ==== src/ssp_pkg.sv ====
// Types shared by the serial port modules.
// Assumes ssp_cfg.svh is on the include path.
`include "ssp_cfg.svh"
package ssp_pkg;
  typedef enum logic [1:0] {
    SSP_SH_IDLE = 2'b01,
    SSP_SH_RUN = 2'b10
  } ssp_shift_e;
  typedef logic [3:0] ssp_mode_t;
endpackage

// ==== src/ssp_shift_if.sv ====
// Link between the register block and the byte shift engine.
// Assumes both ends run on the same system clock.
`timescale 1ns/10ps
interface ssp_shift_if;
  logic enable;
  logic master;
  logic clock_polarity;
  logic use_tmr;
  logic tmr_tick;
  logic [5:0] half;
  logic load;
  logic [7:0] load_data;
  logic abort;
  logic s_lead;
  logic s_trail;
  logic sdi;
  logic busy;
  logic done;
  logic [7:0] rx_data;
  logic sdo;
  logic sck;
  modport regs(output enable, master, clock_polarity, use_tmr, tmr_tick, half, load, load_data, abort, s_lead, s_trail,
               sdi, input busy, done, rx_data, sdo, sck);
  modport engine(input enable, master, clock_polarity, use_tmr, tmr_tick, half, load, load_data, abort, s_lead, s_trail,
                 sdi, output busy, done, rx_data, sdo, sck);
endinterface

// ==== src/ssp_shifter.sv ====
// Eight-bit shift engine, MSB first, master clock generation or slave edges.
// Assumes slave edges arrive as one-cycle strobes already sorted by polarity.
`timescale 1ns/10ps
`include "ssp_cfg.svh"
module ssp_shifter (
  input wire logic clk,
  input wire logic rst_n,
  ssp_shift_if.engine sif
);
  ssp_pkg::ssp_shift_e state;
  logic [3:0] cnt;
  logic [5:0] div;
  logic [7:0] sh;
  logic smp;
  logic sck;
  logic done;
  logic tick;
  logic lead;
  logic trail;
  logic run;

  assign run = (state == ssp_pkg::SSP_SH_RUN);
  assign tick = sif.use_tmr ? sif.tmr_tick : (div == sif.half - 6'h01);
  assign lead = sif.master ? (run && tick && !cnt[0]) : sif.s_lead;
  assign trail = sif.master ? (run && tick && cnt[0]) : sif.s_trail;
  assign sif.busy = run;
  assign sif.done = done;
  assign sif.rx_data = sh;
  assign sif.sdo = sh[7];
  assign sif.sck = sck;

  // ==========================================
  // Master rate divider
  always_ff @(posedge clk) begin
    if (!rst_n || !run || !sif.master || tick) begin
      div <= 6'h00;
    end else begin
      div <= div + 6'h01;
    end
  end

  // ==========================================
  // Master clock: idles at polarity, toggles each half period
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sck <= 1'b0;
    end else if (!run || !sif.master) begin
      sck <= sif.clock_polarity;
    end else if (tick) begin
      sck <= ~sck;
    end
  end

  // ==========================================
  // Sequencing and shifting
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state <= ssp_pkg::SSP_SH_IDLE;
      cnt <= 4'h0;
      sh <= `SSP_BYTE_RST;
      smp <= 1'b0;
      done <= 1'b0;
    end else if (!sif.enable || sif.abort) begin
      state <= ssp_pkg::SSP_SH_IDLE;
      cnt <= 4'h0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      case (state)
        ssp_pkg::SSP_SH_IDLE: begin
          if (sif.load) begin
            sh <= sif.load_data;
            if (sif.master) begin
              state <= ssp_pkg::SSP_SH_RUN;
            end
          end else if (!sif.master && lead) begin
            state <= ssp_pkg::SSP_SH_RUN;
            cnt <= 4'h1;
          end
        end
        ssp_pkg::SSP_SH_RUN: begin
          // Drive on the leading edge, sample on the trailing one
          if (lead) begin
            if (cnt != 4'h0) begin
              sh <= {sh[6:0], smp};
            end
            cnt <= cnt + 4'h1;
          end else if (trail) begin
            if (cnt == `SSP_LAST_EDGE) begin
              sh <= {sh[6:0], sif.sdi};
              cnt <= 4'h0;
              done <= 1'b1;
              state <= ssp_pkg::SSP_SH_IDLE;
            end else begin
              smp <= sif.sdi;
              cnt <= cnt + 4'h1;
            end
          end
        end
        default: begin
          state <= ssp_pkg::SSP_SH_IDLE;
        end
      endcase
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_done_ends_run: assert property (done |-> state == ssp_pkg::SSP_SH_IDLE && cnt == 4'h0)
    else $error("shift done without returning to idle");
  a_master_sck_idle: assert property ((sif.master && !run) |=> sck == $past(sif.clock_polarity))
    else $error("master clock not at idle polarity");
endmodule

// ==== src/ssp_top.sv ====
// Synchronous serial port: APB registers, data buffer, status flags, SPI engine and pin enables.
// Assumes all inputs are synchronous to I_MCLK and an external I2C byte engine reports events.
//
// The implementer's own choice: the APB interface to the registers.
`timescale 1ns/10ps
`include "ssp_cfg.svh"
module ssp_top (
  input wire logic I_MCLK,
  input wire logic I_NRST,
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [7:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  output logic [31:0] O_PRDATA,
  output logic O_PREADY,
  output logic O_PSLVERR,
  input wire logic I_TMR_TICK,
  input wire logic I_SCK,
  output logic O_SCK,
  output logic O_SCK_OE,
  input wire logic I_SDI,
  output logic O_SDO,
  output logic O_SDO_OE,
  input wire logic I_SS_N,
  input wire logic I_SCL,
  output logic O_SCL,
  output logic O_SCL_OE,
  input wire logic I_SDA,
  output logic O_SDA,
  output logic O_SDA_OE,
  input wire logic I_I2C_SDA_LOW,
  input wire logic I_I2C_BYTE_DONE,
  input wire logic [7:0] I_I2C_BYTE,
  input wire logic I_I2C_IS_DATA,
  input wire logic I_I2C_ADDR_MATCH,
  input wire logic I_I2C_RW,
  input wire logic I_I2C_UA_REQ,
  input wire logic I_I2C_TX_DONE,
  output logic [7:0] O_I2C_TX_DATA,
  output logic O_I2C_TX_LOAD,
  output logic [7:0] O_OWN_ADDR,
  output logic O_PORT_ENABLE
);
  ssp_shift_if sif();

  function automatic logic is_spi(input ssp_pkg::ssp_mode_t m);
    is_spi = (m <= `SSP_M_SLV_NOSS);
  endfunction

  function automatic logic is_tenbit(input ssp_pkg::ssp_mode_t m);
    is_tenbit = (m == `SSP_M_I2C10) || (m == `SSP_M_I2C10SP);
  endfunction

  ssp_pkg::ssp_mode_t mode;
  logic port_en;
  logic clock_polarity;
  logic write_collision_flag;
  logic ov;
  logic [7:0] data_buf;
  logic bf;
  logic tx_pend;
  logic flag_da;
  logic flag_p;
  logic flag_s;
  logic flag_rw;
  logic flag_ua;
  logic sck_prev;
  logic scl_prev;
  logic sda_prev;
  logic fire;
  logic ctrl_wr;
  logic buf_wr;
  logic buf_rd;
  logic spi;
  logic i2c;
  logic master;
  logic ss_off;
  logic spi_done;
  logic spi_ovf;
  logic i2c_rx;
  logic i2c_ovf;
  logic collide;
  logic start_det;
  logic stop_det;
  logic [7:0] status;
  logic [7:0] ctrl;
  logic [31:0] next_prdata;
  logic next_err;

  // ==========================================
  // Decode
  assign spi = is_spi(mode);
  assign i2c = !spi;
  assign master = spi && (mode <= `SSP_M_TMR);
  assign ss_off = (mode == `SSP_M_SLV_SS) && I_SS_N;
  assign fire = I_PSEL && I_PENABLE && O_PREADY;
  assign ctrl_wr = fire && I_PWRITE && (I_PADDR == `SSP_OFF_CTRL);
  assign buf_wr = fire && I_PWRITE && (I_PADDR == `SSP_OFF_BUF);
  assign buf_rd = fire && !I_PWRITE && (I_PADDR == `SSP_OFF_BUF);
  assign spi_done = spi && sif.done;
  assign spi_ovf = spi_done && bf && !master;
  assign i2c_rx = i2c && port_en && I_I2C_BYTE_DONE && !tx_pend;
  assign i2c_ovf = i2c_rx && bf;
  assign collide = buf_wr && (spi ? sif.busy : tx_pend);
  assign start_det = I_SCL && scl_prev && sda_prev && !I_SDA;
  assign stop_det = I_SCL && scl_prev && !sda_prev && I_SDA;
  assign status = {2'b00, flag_da, flag_p, flag_s, flag_rw, flag_ua, bf};
  assign ctrl = {write_collision_flag, ov, port_en, clock_polarity, mode};

  // ==========================================
  // Shift engine
  assign sif.enable = port_en && spi;
  assign sif.master = master;
  assign sif.clock_polarity = clock_polarity;
  assign sif.use_tmr = (mode == `SSP_M_TMR);
  assign sif.tmr_tick = I_TMR_TICK;
  assign sif.half = (mode == `SSP_M_DIV4) ? `SSP_HALF_DIV4 :
                    (mode == `SSP_M_DIV16) ? `SSP_HALF_DIV16 : `SSP_HALF_DIV64;
  assign sif.load = buf_wr && !sif.busy && spi && port_en;
  assign sif.load_data = I_PWDATA[7:0];
  assign sif.abort = ss_off;
  assign sif.s_lead = clock_polarity ? (sck_prev && !I_SCK) : (!sck_prev && I_SCK);
  assign sif.s_trail = clock_polarity ? (!sck_prev && I_SCK) : (sck_prev && !I_SCK);
  assign sif.sdi = I_SDI;
  assign O_SCK = sif.sck;
  assign O_SDO = sif.sdo;
  assign O_SCL = 1'b0;
  assign O_SDA = 1'b0;
  assign O_PORT_ENABLE = port_en;

  ssp_shifter u_shifter (
    .clk(I_MCLK),
    .rst_n(I_NRST),
    .sif(sif)
  );

  // ==========================================
  // APB answer: ready in the first access cycle
  always_comb begin
    next_prdata = 32'h0000_0000;
    next_err = 1'b0;
    if (I_PADDR == `SSP_OFF_CTRL) begin
      next_prdata[7:0] = ctrl;
    end else if (I_PADDR == `SSP_OFF_STAT) begin
      next_prdata[7:0] = status;
    end else if (I_PADDR == `SSP_OFF_BUF) begin
      next_prdata[7:0] = data_buf;
    end else if (I_PADDR == `SSP_OFF_ADDR) begin
      next_prdata[7:0] = O_OWN_ADDR;
    end else begin
      next_err = 1'b1;
    end
  end

  always_ff @(posedge I_MCLK) begin
    if (!I_NRST) begin
      O_PREADY <= 1'b0;
      O_PSLVERR <= 1'b0;
      O_PRDATA <= 32'h0000_0000;
    end else begin
      O_PREADY <= I_PSEL && !I_PENABLE;
      O_PSLVERR <= I_PSEL && !I_PENABLE && next_err;
      if (I_PSEL && !I_PENABLE && !I_PWRITE) begin
        O_PRDATA <= next_prdata;
      end
    end
  end

  // ==========================================
  // Control register; status offset takes writes silently
  always_ff @(posedge I_MCLK) begin
    if (!I_NRST) begin
      port_en <= 1'b0;
      clock_polarity <= 1'b0;
      mode <= `SSP_M_DIV4;
      O_OWN_ADDR <= `SSP_BYTE_RST;
    end else begin
      if (ctrl_wr) begin
        port_en <= I_PWDATA[`SSP_BIT_EN];
        clock_polarity <= I_PWDATA[`SSP_BIT_CKP];
        mode <= I_PWDATA[3:0];
      end
      if (fire && I_PWRITE && (I_PADDR == `SSP_OFF_ADDR)) begin
        O_OWN_ADDR <= I_PWDATA[7:0];
      end
    end
  end

  // ==========================================
  // Sticky error flags: hardware set wins over software write
  always_ff @(posedge I_MCLK) begin
    if (!I_NRST) begin
      write_collision_flag <= 1'b0;
      ov <= 1'b0;
    end else begin
      if (collide) begin
        write_collision_flag <= 1'b1;
      end else if (ctrl_wr) begin
        write_collision_flag <= I_PWDATA[`SSP_BIT_WRITE_COLLISION_FLAG];
      end
      if (spi_ovf || i2c_ovf) begin
        ov <= 1'b1;
      end else if (ctrl_wr) begin
        ov <= I_PWDATA[`SSP_BIT_OV];
      end
    end
  end

  // ==========================================
  // Data buffer and buffer-full
  always_ff @(posedge I_MCLK) begin
    if (!I_NRST) begin
      data_buf <= `SSP_BYTE_RST;
      bf <= 1'b0;
      tx_pend <= 1'b0;
      O_I2C_TX_DATA <= `SSP_BYTE_RST;
      O_I2C_TX_LOAD <= 1'b0;
    end else begin
      O_I2C_TX_LOAD <= 1'b0;
      if (sif.load) begin
        data_buf <= I_PWDATA[7:0];
      end
      if (spi_done && !spi_ovf) begin
        data_buf <= sif.rx_data;
        bf <= 1'b1;
      end else if (i2c_rx && !i2c_ovf) begin
        data_buf <= I_I2C_BYTE;
        bf <= 1'b1;
      end else if (i2c && port_en && buf_wr && !tx_pend) begin
        data_buf <= I_PWDATA[7:0];
        O_I2C_TX_DATA <= I_PWDATA[7:0];
        O_I2C_TX_LOAD <= 1'b1;
        tx_pend <= 1'b1;
        bf <= 1'b1;
      end else if (tx_pend && (I_I2C_TX_DONE || !port_en)) begin
        tx_pend <= 1'b0;
        bf <= 1'b0;
      end else if (buf_rd) begin
        bf <= 1'b0;
      end
    end
  end

  // ==========================================
  // I2C start and stop from the bus lines
  always_ff @(posedge I_MCLK) begin
    if (!I_NRST) begin
      scl_prev <= 1'b1;
      sda_prev <= 1'b1;
      sck_prev <= 1'b0;
      flag_s <= 1'b0;
      flag_p <= 1'b0;
    end else begin
      scl_prev <= I_SCL;
      sda_prev <= I_SDA;
      sck_prev <= I_SCK;
      if (!port_en || !i2c) begin
        flag_s <= 1'b0;
        flag_p <= 1'b0;
      end else if (start_det) begin
        flag_s <= 1'b1;
        flag_p <= 1'b0;
      end else if (stop_det) begin
        flag_p <= 1'b1;
        flag_s <= 1'b0;
      end
    end
  end

  // ==========================================
  // I2C byte status
  always_ff @(posedge I_MCLK) begin
    if (!I_NRST) begin
      flag_da <= 1'b0;
      flag_rw <= 1'b0;
      flag_ua <= 1'b0;
    end else if (!i2c || !port_en) begin
      flag_ua <= 1'b0;
    end else begin
      if (I_I2C_BYTE_DONE) begin
        flag_da <= I_I2C_IS_DATA;
      end
      if (I_I2C_ADDR_MATCH) begin
        flag_rw <= I_I2C_RW;
      end
      if (I_I2C_UA_REQ && is_tenbit(mode)) begin
        flag_ua <= 1'b1;
      end else if (!is_tenbit(mode) || (fire && I_PWRITE && (I_PADDR == `SSP_OFF_ADDR))) begin
        flag_ua <= 1'b0;
      end
    end
  end

  // ==========================================
  // Pin ownership
  always_ff @(posedge I_MCLK) begin
    if (!I_NRST) begin
      O_SCK_OE <= 1'b0;
      O_SDO_OE <= 1'b0;
      O_SCL_OE <= 1'b0;
      O_SDA_OE <= 1'b0;
    end else begin
      O_SCK_OE <= port_en && master;
      O_SDO_OE <= port_en && spi && !ss_off;
      O_SCL_OE <= port_en && i2c && !clock_polarity;
      O_SDA_OE <= port_en && i2c && I_I2C_SDA_LOW;
    end
  end

  default clocking cb @(posedge I_MCLK); endclocking
  default disable iff (!I_NRST);

  a_status_top_zero: assert property ((I_PSEL && !I_PENABLE && !I_PWRITE && I_PADDR == `SSP_OFF_STAT)
    |=> O_PRDATA[7:6] == 2'b00)
    else $error("status top bits not zero");
  a_stop_start_dis: assert property (!port_en |=> !flag_p && !flag_s)
    else $error("start or stop flag kept while disabled");
  a_start_seen: assert property ((port_en && i2c && start_det) |=> flag_s && !flag_p)
    else $error("start not recorded");
  a_rw_capture: assert property ((port_en && i2c && I_I2C_ADDR_MATCH) |=> flag_rw == $past(I_I2C_RW))
    else $error("direction not captured");
  a_ua_tenbit: assert property (!is_tenbit(mode) |=> !flag_ua)
    else $error("address update outside ten-bit mode");
  a_write_collision_flag_sticky: assert property ((write_collision_flag && !ctrl_wr) |=> write_collision_flag)
    else $error("collision flag dropped");
  a_collide_ignored: assert property ((collide && spi) |=> data_buf == $past(data_buf) || $past(spi_done))
    else $error("colliding write changed buffer");
  a_ovf_keep: assert property (spi_ovf |=> ov && data_buf == $past(data_buf) && bf)
    else $error("overflow did not keep buffer");
  a_master_no_ovf: assert property ((master && !ov && !ctrl_wr) |=> !ov)
    else $error("overflow set in master mode");
  a_read_clr_bf: assert property ((buf_rd && spi && !spi_done) |=> !bf)
    else $error("buffer read left buffer-full set");
  a_status_wr_none: assert property ((fire && I_PWRITE && I_PADDR == `SSP_OFF_STAT) |=> $stable(ctrl[5:0]))
    else $error("status write changed control");
endmodule

// ==== verification/ssp_spi_peer.sv ====
// Far-side SPI device: answers a master port or clocks a slave port.
// Assumes one system clock; edges are found by sampling the serial clock on it.
`timescale 1ns/10ps
module ssp_spi_peer (
  input wire logic i_clk,
  input wire logic i_ckp,
  input wire logic i_drive,
  input wire logic i_sck,
  input wire logic i_sdo,
  input wire logic i_go,
  input wire logic [7:0] i_tx,
  output logic o_sck,
  output logic o_sdi,
  output logic [7:0] o_rx,
  output logic o_busy
);
  logic prev;
  logic sdo_d;
  logic [7:0] sr;
  logic [3:0] lead;
  logic [4:0] tog;
  logic [1:0] div;
  logic sck;
  // ==========================================
  // Shift data: first bit stands before the first leading edge
  assign sck = i_drive ? o_sck : i_sck;
  assign o_sdi = sr[7];
  initial begin
    {o_sck, prev, sdo_d, sr, lead, tog, div, o_rx, o_busy} = '0;
  end
  always @(posedge i_clk) begin
    prev <= sck;
    // Data as it stood at the clock edge itself, before the port moves on
    sdo_d <= i_sdo;
    if (i_go) begin
      sr <= i_tx;
      lead <= 4'h0;
      tog <= 5'h00;
      div <= 2'h0;
      o_busy <= i_drive;
    end else begin
      if (sck != i_ckp && prev == i_ckp) begin
        lead <= lead + 4'h1;
        if (lead != 4'h0) sr <= {sr[6:0], ~sr[7]};
      end
      if (sck == i_ckp && prev != i_ckp) o_rx <= {o_rx[6:0], sdo_d};
      if (!o_busy) o_sck <= i_ckp;
      else begin
        div <= div + 2'h1;
        if (div == 2'h3) begin
          o_sck <= ~o_sck;
          tog <= tog + 5'h01;
          if (tog == 5'h0F) o_busy <= 1'b0;
        end
      end
    end
  end
endmodule

// ==== verification/testbench.sv ====
// Self-checking bench for the serial port: APB accesses, SPI peer, I2C events.
// Assumes ssp_cfg.svh on the include path and the peer model beside it.
`timescale 1ns/10ps
`include "ssp_cfg.svh"
module testbench;
  logic clk = 0, nrst = 0, psel = 0, pen = 0, pwr = 0, tick = 0, ss_n = 1, scl = 1, sda = 1, sda_low = 0;
  logic bdone = 0, isdata = 0, amatch = 0, rw = 0, uareq = 0, txdone = 0, clock_polarity = 0, drive = 0, pgo = 0;
  logic [7:0] paddr = 0, ibyte = 0, ptx = 0;
  logic [31:0] pwdata = 0, prdata, q;
  logic pready, pslverr, er, sck_o, sck_oe, sdo, sdo_oe, scl_oe, sda_oe, port_en, psck, psdi, pbusy;
  logic txl, scl_o, sda_o;
  logic [7:0] txd, own, prx;
  int miscompares = 0, total_checks = 0, cycles = 0;
  ssp_top uut (.I_MCLK(clk), .I_NRST(nrst), .I_PSEL(psel), .I_PENABLE(pen), .I_PWRITE(pwr), .I_PADDR(paddr),
    .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr), .I_TMR_TICK(tick),
    .I_SCK(psck), .O_SCK(sck_o), .O_SCK_OE(sck_oe), .I_SDI(psdi), .O_SDO(sdo), .O_SDO_OE(sdo_oe),
    .I_SS_N(ss_n), .I_SCL(scl), .O_SCL(scl_o), .O_SCL_OE(scl_oe), .I_SDA(sda), .O_SDA(sda_o), .O_SDA_OE(sda_oe),
    .I_I2C_SDA_LOW(sda_low), .I_I2C_BYTE_DONE(bdone), .I_I2C_BYTE(ibyte), .I_I2C_IS_DATA(isdata),
    .I_I2C_ADDR_MATCH(amatch), .I_I2C_RW(rw), .I_I2C_UA_REQ(uareq), .I_I2C_TX_DONE(txdone),
    .O_I2C_TX_DATA(txd), .O_I2C_TX_LOAD(txl), .O_OWN_ADDR(own), .O_PORT_ENABLE(port_en));
  ssp_spi_peer peer (.i_clk(clk), .i_ckp(clock_polarity), .i_drive(drive), .i_sck(sck_o), .i_sdo(sdo), .i_go(pgo),
    .i_tx(ptx), .o_sck(psck), .o_sdi(psdi), .o_rx(prx), .o_busy(pbusy));
  // ==========================================
  // Clock, timer tick and hang guard
  always #50 clk = ~clk;
  always @(posedge clk) begin
    tick <= (cycles % 8 == 0);
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      miscompares++;
      complete_run();
    end
  end
  // ==========================================
  // Tasks
  task complete_run();
    if (miscompares == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1; pen <= 0; pwr <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    pen <= 1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
    er = pslverr;
    psel <= 0; pen <= 0;
    @(posedge clk);
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1, a, d);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = 32'hFFFFFFFF);
    apb(0, a, 32'h0);
    chk(q & m, e);
  endtask
  task wait_bf();
    repeat (100) begin
      apb(0, `SSP_OFF_STAT, 32'h0);
      if (q[0] === 1'b1) break;
    end
  endtask
  task peer_go(input logic [7:0] t);
    ptx <= t; pgo <= 1;
    @(posedge clk);
    pgo <= 0;
    repeat (2) @(posedge clk);
    while (pbusy === 1'b1) @(posedge clk);
    repeat (6) @(posedge clk);
  endtask
  task ev(input logic [3:0] p);
    {bdone, amatch, uareq, txdone} <= p;
    @(posedge clk);
    {bdone, amatch, uareq, txdone} <= 4'h0;
    @(posedge clk);
  endtask
  // ==========================================
  // Main sequence
  initial begin
    repeat (16) @(posedge clk);
    nrst <= 1;
    @(posedge clk);
    rd(`SSP_OFF_CTRL, 32'h00);
    rd(`SSP_OFF_STAT, 32'h00);
    apb(0, 8'h40, 32'h0);
    chk(q, 32'h0);
    chk(er, 1'b1);
    wr(`SSP_OFF_STAT, 32'hFF);
    rd(`SSP_OFF_STAT, 32'h00);
    for (int m = 0; m < 8; m++) begin
      wr(`SSP_OFF_CTRL, 32'h20 | m);
      @(posedge clk);
      chk({sck_oe, port_en}, {m < 4, 1'b1});
      if (m > 5) chk(scl_oe, 1);
    end
    wr(`SSP_OFF_CTRL, 32'h24);
    @(posedge clk);
    chk(sdo_oe, 0);
    ss_n <= 0;
    wr(`SSP_OFF_CTRL, 32'h20);
    @(posedge clk);
    chk({sck_oe, sdo_oe}, 2'b11);
    ptx <= 8'h3C; pgo <= 1;
    @(posedge clk);
    pgo <= 0;
    wr(`SSP_OFF_BUF, 32'hA5);
    wr(`SSP_OFF_BUF, 32'h11);
    wait_bf();
    rd(`SSP_OFF_CTRL, 32'hA0);
    chk(prx, 8'hA5);
    rd(`SSP_OFF_BUF, 32'h3C);
    rd(`SSP_OFF_STAT, 32'h00);
    wr(`SSP_OFF_CTRL, 32'h30);
    rd(`SSP_OFF_CTRL, 32'h30);
    clock_polarity <= 1;
    @(posedge clk);
    chk(sck_o, 1);
    wr(`SSP_OFF_BUF, 32'h5A);
    wait_bf();
    chk(prx, 8'h5A);
    wr(`SSP_OFF_BUF, 32'h00);
    repeat (60) @(posedge clk);
    rd(`SSP_OFF_CTRL, 32'h30);
    rd(`SSP_OFF_BUF, 32'h0, 32'h0);
    wr(`SSP_OFF_CTRL, 32'h35);
    drive <= 1;
    peer_go(8'h96);
    rd(`SSP_OFF_STAT, 32'h01);
    peer_go(8'h69);
    rd(`SSP_OFF_CTRL, 32'h75);
    rd(`SSP_OFF_BUF, 32'h96);
    drive <= 0; clock_polarity <= 0;
    wr(`SSP_OFF_CTRL, 32'h26);
    sda <= 0;
    repeat (2) @(posedge clk);
    rd(`SSP_OFF_STAT, 32'h08);
    scl <= 0;
    @(posedge clk);
    scl <= 1;
    @(posedge clk);
    sda <= 1;
    repeat (2) @(posedge clk);
    rd(`SSP_OFF_STAT, 32'h10);
    ibyte <= 8'h5C; isdata <= 1;
    ev(4'h8);
    rd(`SSP_OFF_STAT, 32'h31);
    rd(`SSP_OFF_BUF, 32'h5C);
    ibyte <= 8'hA1; isdata <= 0; rw <= 1;
    ev(4'hC);
    rd(`SSP_OFF_STAT, 32'h15);
    rd(`SSP_OFF_BUF, 32'hA1);
    wr(`SSP_OFF_BUF, 32'hE7);
    chk({txl, txd}, {1'b1, 8'hE7});
    rd(`SSP_OFF_STAT, 32'h15);
    ev(4'h1);
    rd(`SSP_OFF_STAT, 32'h14);
    wr(`SSP_OFF_CTRL, 32'h27);
    ev(4'h2);
    rd(`SSP_OFF_STAT, 32'h16);
    wr(`SSP_OFF_ADDR, 32'h3A);
    chk(own, 8'h3A);
    rd(`SSP_OFF_STAT, 32'h14);
    sda_low <= 1;
    repeat (2) @(posedge clk);
    chk(sda_oe, 1);
    chk({scl_o, sda_o}, 2'b00);
    wr(`SSP_OFF_CTRL, 32'h07);
    @(posedge clk);
    chk({sda_oe, scl_oe, port_en}, 3'b000);
    rd(`SSP_OFF_STAT, 32'h00, 32'h18);
    complete_run();
  end
endmodule
